/* tb/acsc_audio_src.sv */
/*
 Audio source model: mclk, sclk and lrclk edge pulses per frame.
 Assumes the bench picks legal rate and ratio pairs.
*/
`default_nettype none
module acsc_audio_src (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Frame settings
   input wire logic [15:0] frame_len,
   input wire logic [9:0] mclk_per,
   input wire logic [6:0] sclk_per,
   // Edge pulses
   output logic mclk_rise,
   output logic sclk_rise,
   output logic lrclk_rise
);
   logic [15:0] cnt_reg;
   logic [32:0] cfg_reg;
   // Settings latched only between frames
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 16'h0000;
         cfg_reg <= 33'h0;
      end else if (cnt_reg + 16'h0001 >= cfg_reg[32:17]) begin
         cnt_reg <= 16'h0000;
         cfg_reg <= {frame_len, mclk_per, sclk_per};
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end
   assign lrclk_rise = rst_n && cnt_reg == 16'h0000;
   assign mclk_rise = rst_n && cnt_reg < {6'h00, cfg_reg[16:7]};
   assign sclk_rise = rst_n && cnt_reg < {9'h000, cfg_reg[6:0]};
endmodule : acsc_audio_src
`default_nettype wire

/* tb/acsc_regs_properties.sv */
/*
 Port assertions for the register group.
 Assumes a bind from the bench top.
*/
`default_nettype none
module acsc_regs_properties
   import acsc_pkg::*;
#(
   parameter logic [7:0] FW_ID = 8'h00
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Status and control
   input wire logic pll_unlock,
   input wire acsc_ctrl_type ctrl,
   input wire logic [2:0] sample_rate_freq,
   input wire logic [2:0] mclk_ratio
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd(logic [7:0] off);
      reg_rd && reg_addr == off;
   endsequence
   sequence s_wr(logic [7:0] off);
      reg_wr && reg_addr == off;
   endsequence
   sequence s_pll_rd;
      pll_unlock ##1 !reg_wr ##1 s_rd(ACSC_OFF_ERR_FLAGS);
   endsequence
   chk_id_read:
      assert property (s_rd(ACSC_OFF_FW_ID) |=> reg_rdata == FW_ID) else $error("id read");
   chk_status_read:
      assert property (s_rd(ACSC_OFF_CLK_STATUS) |=> reg_rdata ==
         {$past(sample_rate_freq), $past(mclk_ratio), 2'b00}) else $error("status read");
   chk_rate_code:
      assert property (sample_rate_freq != 3'h1 && sample_rate_freq != 3'h2) else $error("rate");
   chk_ratio_code:
      assert property (mclk_ratio < 3'h6) else $error("ratio code");
   chk_ctrl_write:
      assert property (s_wr(ACSC_OFF_SYS_CTRL1) |=> ctrl[7:4] == {$past(reg_wdata[7]),
         $past(reg_wdata[5]), $past(reg_wdata[1:0])}) else $error("ctrl write");
   chk_ctrl_hold:
      assert property (!reg_wr |=> $stable(ctrl)) else $error("ctrl moved");
   chk_fmt_write:
      assert property (s_wr(ACSC_OFF_FORMAT) ##0 reg_wdata < 8'h09 |=>
         ctrl.format_sel == $past(reg_wdata[3:0])) else $error("format write");
   chk_fmt_range:
      assert property (ctrl.format_sel <= ACSC_FMT_MAX) else $error("format range");
   chk_pll_sticky:
      assert property (s_pll_rd |=> reg_rdata[6]) else $error("pll flag");
   chk_err_rsvd:
      assert property (s_rd(ACSC_OFF_ERR_FLAGS) |=> !reg_rdata[0]) else $error("err bit0");
endmodule : acsc_regs_properties
`default_nettype wire

/* tb/tb_top.sv */
/*
 Bench for the register group with an audio source model.
 Assumes reg_rdata answers one cycle after reg_rd.
*/
`default_nettype none
module tb_top
   import acsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] TB_ID = 8'h3c; // Arbitrary value
   logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v, cur;
   logic [2:0] flt = 3'h0;
   logic [15:0] fl = 16'd3000;
   logic [9:0] mp = 10'd384;
   logic [6:0] sp = 7'd64;
   logic mr, sr, lr;
   logic [2:0] srf, mrt;
   acsc_ctrl_type ctrl;
   logic [31:0] seed = 32'd52;
   int error_cnt = 0, n_checks = 0;
   int fl_t[3] = '{2083, 3000, 7500};
   int mp_t[3] = '{256, 384, 512};
   always #5 ref_clk = ~ref_clk;
   acsc_audio_src u_src (.ref_clk(ref_clk), .rst_n(rst_n), .frame_len(fl), .mclk_per(mp),
      .sclk_per(sp), .mclk_rise(mr), .sclk_rise(sr), .lrclk_rise(lr));
   acsc_regs #(.FW_ID(TB_ID)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mclk_rise(mr), .sclk_rise(sr), .lrclk_rise(lr), .pll_unlock(flt[2]),
      .clip_detect(flt[1]), .power_fault(flt[0]), .ctrl(ctrl), .sample_rate_freq(srf),
      .mclk_ratio(mrt));
   function automatic logic [7:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : xs
   function automatic logic [7:0] exp_stat(int f, int m);
      logic [2:0] r;
      r = f < 2500 ? ACSC_SR_48K : f < 3571 ? ACSC_SR_32K : f < 5000 ? ACSC_SR_24K :
         f < 7142 ? ACSC_SR_16K : f < 10000 ? ACSC_SR_12K : ACSC_SR_8K;
      return {r, m == 256 ? ACSC_MR_256 : m == 384 ? ACSC_MR_384 : ACSC_MR_512, 2'b00};
   endfunction : exp_stat
   task automatic close_out();
      if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      chk(reg_rdata & m, e);
      @(posedge ref_clk);
   endtask : rd
   task automatic wait_fr(input int n);
      int k;
      k = 0;
      while (n > 0) begin
         @(negedge ref_clk);
         k++;
         if (lr) n--;
         if (k > 40000) begin
            error_cnt++;
            close_out();
         end
      end
      @(posedge ref_clk);
   endtask : wait_fr
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      wr(8'h00, 8'hff);
      wr(8'h01, 8'hff);
      rd(8'h00, 8'hff, 8'h6c);
      rd(8'h01, 8'hff, TB_ID);
      rd(8'h02, 8'hff, ACSC_RST_ERR_FLAGS);
      rd(8'h03, 8'hff, ACSC_RST_SYS_CTRL1);
      rd(8'h04, 8'hff, {4'h0, ACSC_RST_FORMAT});
      rd(8'h07, 8'hff, 8'h00);
      for (int i = 0; i < 8; i++) begin
         v = {xs() & 8'hfc | i[1:0]};
         wr(8'h03, v);
         chk(ctrl[7:4], {v[7], v[5], v[1:0]});
         rd(8'h03, 8'hff, v & 8'ha3);
      end
      cur = {4'h0, ACSC_RST_FORMAT};
      for (int i = 0; i < 16; i++) begin
         wr(8'h04, (xs() & 8'h70) | 8'h11);
         wr(8'h04, i[7:0]);
         if (i < 9) cur = i[7:0];
         rd(8'h04, 8'hff, cur);
         chk({4'h0, ctrl.format_sel}, cur);
      end
      wait_fr(2);
      wr(8'h02, 8'h00);
      for (int i = 0; i < 3; i++) begin
         fl <= fl_t[i][15:0];
         mp <= mp_t[i][9:0];
         sp <= i == 2 ? 7'd32 : 7'd64;
         wait_fr(3);
         rd(8'h02, 8'hb0, i == 2 ? 8'hb0 : 8'h90);
         wr(8'h02, 8'h00);
         wait_fr(2);
         rd(8'h02, 8'hb9, 8'h00);
         rd(8'h00, 8'hff, exp_stat(fl_t[i], mp_t[i]));
         chk({srf, mrt, 2'b00}, exp_stat(fl_t[i], mp_t[i]));
      end
      for (int i = 0; i < 3; i++) begin
         flt <= 3'h4 >> i;
         @(posedge ref_clk);
         flt <= 3'h0;
         @(posedge ref_clk);
         v = i == 0 ? 8'h40 : i == 1 ? 8'h04 : 8'h02;
         rd(8'h02, 8'h46, v);
         rd(8'h02, 8'h46, v);
         wr(8'h02, 8'h00);
         rd(8'h02, 8'h46, 8'h00);
      end
      close_out();
   end
endmodule : tb_top
bind acsc_regs acsc_regs_properties #(.FW_ID(FW_ID)) u_props (.ref_clk(ref_clk),
   .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pll_unlock(pll_unlock), .ctrl(ctrl),
   .sample_rate_freq(sample_rate_freq), .mclk_ratio(mclk_ratio));
`default_nettype wire

/* verilog/acsc_pkg.sv */
/*
 Constants and carrier types for the amplifier clock, status and control
 register group. Assumes a single 100 MHz clock domain.
*/
`default_nettype none
package acsc_pkg;
   // Register offsets
   localparam logic [7:0] ACSC_OFF_CLK_STATUS = 8'h00;
   localparam logic [7:0] ACSC_OFF_FW_ID = 8'h01;
   localparam logic [7:0] ACSC_OFF_ERR_FLAGS = 8'h02;
   localparam logic [7:0] ACSC_OFF_SYS_CTRL1 = 8'h03;
   localparam logic [7:0] ACSC_OFF_FORMAT = 8'h04;
   // Reset values
   localparam logic [7:0] ACSC_RST_SYS_CTRL1 = 8'h80;
   localparam logic [3:0] ACSC_RST_FORMAT = 4'h5;
   localparam logic [7:0] ACSC_RST_ERR_FLAGS = 8'h00;
   // Identification code, arbitrary value
   localparam logic [7:0] ACSC_FW_ID_DEFAULT = 8'h5a;
   // Field positions
   localparam int ACSC_SYS_DCBLOCK_BIT = 7;
   localparam int ACSC_SYS_HARD_UNMUTE_BIT = 5;
   localparam logic [7:0] ACSC_SYS_WR_MASK = 8'ha3;
   localparam int ACSC_ERR_MCLK_BIT = 7;
   localparam int ACSC_ERR_PLL_BIT = 6;
   localparam int ACSC_ERR_SCLK_BIT = 5;
   localparam int ACSC_ERR_LRCLK_BIT = 4;
   localparam int ACSC_ERR_SLIP_BIT = 3;
   localparam int ACSC_ERR_CLIP_BIT = 2;
   localparam int ACSC_ERR_POWER_BIT = 1;
   // Highest legal format code
   localparam logic [3:0] ACSC_FMT_MAX = 4'h8;
   // Sample rate codes
   localparam logic [2:0] ACSC_SR_32K = 3'h0;
   localparam logic [2:0] ACSC_SR_48K = 3'h3;
   localparam logic [2:0] ACSC_SR_16K = 3'h4;
   localparam logic [2:0] ACSC_SR_24K = 3'h5;
   localparam logic [2:0] ACSC_SR_8K = 3'h6;
   localparam logic [2:0] ACSC_SR_12K = 3'h7;
   // Master clock ratio codes
   localparam logic [2:0] ACSC_MR_64 = 3'h0;
   localparam logic [2:0] ACSC_MR_128 = 3'h1;
   localparam logic [2:0] ACSC_MR_192 = 3'h2;
   localparam logic [2:0] ACSC_MR_256 = 3'h3;
   localparam logic [2:0] ACSC_MR_384 = 3'h4;
   localparam logic [2:0] ACSC_MR_512 = 3'h5;
   // Ref clock cycles per frame window limits, 100 MHz / rate
   localparam int ACSC_CLK_HZ = 100000000;
   localparam int ACSC_FRAME_CNT_W = 16;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } acsc_req_type;

   // Control outputs toward the datapath
   typedef struct packed {
      logic dc_block_en;
      logic hard_unmute;
      logic [1:0] deemph_sel;
      logic [3:0] format_sel;
   } acsc_ctrl_type;
endpackage : acsc_pkg
`default_nettype wire

/* verilog/acsc_regs.sv */
/*
 Clock detect, identification, sticky error, system control and format
 registers. Assumes mclk, sclk and lrclk arrive already synchronous to
 ref_clk as single-cycle rising-edge pulses, and power-stage, clip and
 PLL fault levels come from the surrounding chip.
*/
// Added by the designer: the strobed register port.
// What this block does
// - Clock configuration is detected automatically and shown read-only at offset 0x00.
// - Top three status bits give detected sample rate; codes 001, 010 reserved.
// - Bits four to two give master clock ratio 64 to 512; 110, 111 reserved.
// - Read-only eight-bit firmware identification code at offset 0x01.
// - Error bits latch and stay set; only a host write of zero clears.
// - Error bits: 7 mclk, 6 pll, 5 sclk, 4 lrclk, 3 slip, 2 clip, 1 power.
// - Master clock error set when mclk count per frame changes.
// - Bit clock error set when sclk count per frame changes.
// - Frame clock error set when lrclk frequency changes.
// - Frame slip set when lrclk phase drifts from internal frame sync.
// - Control bit 7 enables dc-blocking filter; default enabled.
// - Control bit 5 clear selects soft ramp unmute after clock error recovery.
// - Control bit 5 set selects single-step unmute after clock error recovery.
// - Control bits one to zero select de-emphasis: none, 32, 44.1, 48 kHz.
// - Format register offers nine modes; 24-bit I2S after reset.
// - Format upper nibble zero; codes 0-8 select format, 9-15 reserved.
`default_nettype none
module acsc_regs
   import acsc_pkg::*;
#(
   parameter logic [7:0] FW_ID = ACSC_FW_ID_DEFAULT,
   parameter int CNT_W = ACSC_FRAME_CNT_W
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Audio clock edge pulses
   input wire logic mclk_rise,
   input wire logic sclk_rise,
   input wire logic lrclk_rise,
   // Fault inputs
   input wire logic pll_unlock,
   input wire logic clip_detect,
   input wire logic power_fault,
   // Control outputs
   output acsc_ctrl_type ctrl,
   output logic [2:0] sample_rate_freq,
   output logic [2:0] mclk_ratio
);

   acsc_req_type req;
   logic [CNT_W-1:0] mclk_cnt_reg;
   logic [CNT_W-1:0] sclk_cnt_reg;
   logic [CNT_W-1:0] ref_cnt_reg;
   logic [CNT_W-1:0] last_mclk_reg;
   logic [CNT_W-1:0] last_sclk_reg;
   logic [CNT_W-1:0] last_ref_reg;
   logic [CNT_W-1:0] sync_cnt_reg;
   logic primed_reg;
   logic locked_reg;
   logic [7:0] err_reg;
   logic [7:0] err_set;
   logic [7:0] sys_reg;
   logic [3:0] fmt_reg;
   logic [2:0] sr_reg;
   logic [2:0] mr_reg;
   logic [2:0] sr_next;
   logic [2:0] mr_next;
   logic [7:0] rdata_next;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // Per-frame counters of mclk, sclk and ref_clk
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mclk_cnt_reg <= '0;
         sclk_cnt_reg <= '0;
         ref_cnt_reg <= '0;
      end else if (lrclk_rise) begin
         mclk_cnt_reg <= CNT_W'(mclk_rise);
         sclk_cnt_reg <= CNT_W'(sclk_rise);
         ref_cnt_reg <= CNT_W'(1);
      end else begin
         if (mclk_rise && mclk_cnt_reg != '1) mclk_cnt_reg <= mclk_cnt_reg + CNT_W'(1);
         if (sclk_rise && sclk_cnt_reg != '1) sclk_cnt_reg <= sclk_cnt_reg + CNT_W'(1);
         if (ref_cnt_reg != '1) ref_cnt_reg <= ref_cnt_reg + CNT_W'(1);
      end
   end

   // Previous frame measurements
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         last_mclk_reg <= '0;
         last_sclk_reg <= '0;
         last_ref_reg <= '0;
         primed_reg <= 1'b0;
         locked_reg <= 1'b0;
      end else if (lrclk_rise) begin
         last_mclk_reg <= mclk_cnt_reg;
         last_sclk_reg <= sclk_cnt_reg;
         last_ref_reg <= ref_cnt_reg;
         locked_reg <= primed_reg;
         primed_reg <= 1'b1;
      end
   end

   // Internal frame sync runs on the last measured period, realigned at each frame
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_cnt_reg <= '0;
      end else if (lrclk_rise || sync_cnt_reg + CNT_W'(1) >= last_ref_reg) begin
         sync_cnt_reg <= '0;
      end else begin
         sync_cnt_reg <= sync_cnt_reg + CNT_W'(1);
      end
   end

   // Error events
   always_comb begin
      err_set = '0;
      if (lrclk_rise && locked_reg) begin
         err_set[ACSC_ERR_MCLK_BIT] = mclk_cnt_reg != last_mclk_reg;
         err_set[ACSC_ERR_SCLK_BIT] = sclk_cnt_reg != last_sclk_reg;
         err_set[ACSC_ERR_LRCLK_BIT] = ref_cnt_reg != last_ref_reg;
         err_set[ACSC_ERR_SLIP_BIT] = sync_cnt_reg + CNT_W'(1) != last_ref_reg;
      end
      err_set[ACSC_ERR_PLL_BIT] = pll_unlock;
      err_set[ACSC_ERR_CLIP_BIT] = clip_detect;
      err_set[ACSC_ERR_POWER_BIT] = power_fault;
   end

   // Sticky error flags, set wins over host clear
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         err_reg <= ACSC_RST_ERR_FLAGS;
      end else if (req.wr && req.addr == ACSC_OFF_ERR_FLAGS) begin
         err_reg <= ((err_reg & req.wdata) | err_set) & 8'hfe;
      end else begin
         err_reg <= (err_reg | err_set) & 8'hfe;
      end
   end

   // Clock ratio detect from mclk count over frame
   always_comb begin
      unique case (last_mclk_reg)
         CNT_W'(64): mr_next = ACSC_MR_64;
         CNT_W'(128): mr_next = ACSC_MR_128;
         CNT_W'(192): mr_next = ACSC_MR_192;
         CNT_W'(256): mr_next = ACSC_MR_256;
         CNT_W'(384): mr_next = ACSC_MR_384;
         CNT_W'(512): mr_next = ACSC_MR_512;
         default: mr_next = mr_reg;
      endcase
   end

   // Sample rate detect from ref_clk cycles per frame, band midpoints
   always_comb begin
      if (last_ref_reg < CNT_W'(ACSC_CLK_HZ / 40000)) sr_next = ACSC_SR_48K;
      else if (last_ref_reg < CNT_W'(ACSC_CLK_HZ / 28000)) sr_next = ACSC_SR_32K;
      else if (last_ref_reg < CNT_W'(ACSC_CLK_HZ / 20000)) sr_next = ACSC_SR_24K;
      else if (last_ref_reg < CNT_W'(ACSC_CLK_HZ / 14000)) sr_next = ACSC_SR_16K;
      else if (last_ref_reg < CNT_W'(ACSC_CLK_HZ / 10000)) sr_next = ACSC_SR_12K;
      else sr_next = ACSC_SR_8K;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sr_reg <= ACSC_SR_48K;
         mr_reg <= ACSC_MR_256;
      end else if (locked_reg && lrclk_rise) begin
         sr_reg <= sr_next;
         mr_reg <= mr_next;
      end
   end

   // Control registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sys_reg <= ACSC_RST_SYS_CTRL1;
      end else if (req.wr && req.addr == ACSC_OFF_SYS_CTRL1) begin
         sys_reg <= req.wdata & ACSC_SYS_WR_MASK;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fmt_reg <= ACSC_RST_FORMAT;
      end else if (req.wr && req.addr == ACSC_OFF_FORMAT && req.wdata[7:4] == 4'h0
                   && req.wdata[3:0] <= ACSC_FMT_MAX) begin
         fmt_reg <= req.wdata[3:0];
      end
   end

   // Read mux
   always_comb begin
      unique case (req.addr)
         ACSC_OFF_CLK_STATUS: rdata_next = {sr_reg, mr_reg, 2'b00};
         ACSC_OFF_FW_ID: rdata_next = FW_ID;
         ACSC_OFF_ERR_FLAGS: rdata_next = err_reg;
         ACSC_OFF_SYS_CTRL1: rdata_next = sys_reg;
         ACSC_OFF_FORMAT: rdata_next = {4'h0, fmt_reg};
         default: rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (req.rd) begin
         reg_rdata <= rdata_next;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Datapath controls
   assign ctrl.dc_block_en = sys_reg[ACSC_SYS_DCBLOCK_BIT];
   assign ctrl.hard_unmute = sys_reg[ACSC_SYS_HARD_UNMUTE_BIT];
   assign ctrl.deemph_sel = sys_reg[1:0];
   assign ctrl.format_sel = fmt_reg;
   assign sample_rate_freq = sr_reg;
   assign mclk_ratio = mr_reg;

endmodule : acsc_regs
`default_nettype wire
